// ===== rtl/param_handler_pkg.sv
// Package for the serial parameter handler: parameter numbers, reply codes, fault codes, state codes.
// Assumes a parameter-level request stream from an already decoded serial frame.
package param_handler_pkg;

   // Parameter numbers
   localparam logic [9:0] PAR_START_REQUEST      = 10'h384;
   localparam logic [9:0] PAR_STOP_REQUEST       = 10'h385;
   localparam logic [9:0] PAR_FORWARD_REQUEST    = 10'h386;
   localparam logic [9:0] PAR_REVERSE_REQUEST    = 10'h387;
   localparam logic [9:0] PAR_COMMAND_SOURCE     = 10'h388;
   localparam logic [9:0] PAR_USER_INPUT         = 10'h389;
   localparam logic [9:0] PAR_FAULT_CLEAR        = 10'h38E;
   localparam logic [9:0] PAR_HW_FAULT_PRESENT   = 10'h38F;
   localparam logic [9:0] PAR_SW_FAULT_PRESENT   = 10'h390;
   localparam logic [9:0] PAR_HW_FAULT_FORCE     = 10'h391;
   localparam logic [9:0] PAR_SW_FAULT_FORCE     = 10'h392;
   localparam logic [9:0] PAR_MOTOR_ENERGIZED    = 10'h393;
   localparam logic [9:0] PAR_DRIVE_STATE        = 10'h394;
   localparam logic [9:0] PAR_START_PRESENT      = 10'h395;
   localparam logic [9:0] PAR_DIRECTION          = 10'h396;
   localparam logic [9:0] PAR_INCH_MODE          = 10'h397;
   localparam logic [9:0] PAR_ANALOG_SOURCE      = 10'h398;
   localparam logic [9:0] PAR_PRESET_INDEX       = 10'h399;
   localparam logic [9:0] PAR_GROUP_FIVE_FIRST   = 10'h1F4;
   localparam logic [9:0] PAR_GROUP_FIVE_LAST    = 10'h257;

   // Reply characters
   localparam logic [7:0] CHR_ACK                = 8'h06;
   localparam logic [7:0] CHR_NAK                = 8'h15;
   localparam logic [7:0] CHR_ETX                = 8'h03;
   localparam logic [7:0] CHR_CTRL_LIMIT         = 8'h20;

   // Hardware fault codes
   localparam logic [15:0] HWF_NONE              = 16'h0000;
   localparam logic [15:0] HWF_PEAK_CURRENT      = 16'h0001;
   localparam logic [15:0] HWF_AMBIENT_TEMP      = 16'h0002;
   localparam logic [15:0] HWF_HEATSINK_TEMP     = 16'h0004;
   localparam logic [15:0] HWF_OVERCURRENT       = 16'h0008;
   localparam logic [15:0] HWF_LOGIC_SUPPLY      = 16'h0010;
   localparam logic [15:0] HWF_EXTERNAL          = 16'h0020;
   localparam logic [15:0] HWF_WATCHDOG_FAULT    = 16'h0040;
   localparam logic [15:0] HWF_FEEDBACK_CARD     = 16'h0100;
   localparam logic [15:0] HWF_VALID_MASK        = 16'h017F;

   // Software fault codes
   localparam logic [15:0] SWF_NONE              = 16'h0000;
   localparam logic [15:0] SWF_MEMORY_CHECK      = 16'h0001;
   localparam logic [15:0] SWF_CURRENT_RUNAWAY   = 16'h0002;
   localparam logic [15:0] SWF_MOTOR_RUNAWAY     = 16'h0008;
   localparam logic [15:0] SWF_UNWIRED_MOTOR     = 16'h0010;
   localparam logic [15:0] SWF_CURRENT_LOOP      = 16'h0020;
   localparam logic [15:0] SWF_OVERVOLT_REGEN    = 16'h0040;
   localparam logic [15:0] SWF_OVERVOLT_TRIP     = 16'h0080;
   localparam logic [15:0] SWF_BRAKING           = 16'h0100;
   localparam logic [15:0] SWF_MARKER            = 16'h0200;
   localparam logic [15:0] SWF_HW_SENSE          = 16'h0400;
   localparam logic [15:0] SWF_MEMORY_OUT        = 16'h1000;
   localparam logic [15:0] SWF_UNDERVOLT         = 16'h2000;
   localparam logic [15:0] SWF_SERIAL_RECEIVE    = 16'h4000;
   localparam logic [15:0] SWF_DIRECTION         = 16'h8000;
   localparam logic [15:0] SWF_VALID_MASK        = 16'hF7FB;

   // Drive state codes
   localparam logic [7:0] STC_STOPPED            = 8'h00;
   localparam logic [7:0] STC_JOG_STOP           = 8'h01;
   localparam logic [7:0] STC_TUNING             = 8'h12;
   localparam logic [7:0] STC_UNUSED             = 8'h0D;
   localparam logic [7:0] STC_LAST               = 8'h12;

   // Value limits
   localparam logic [31:0] VAL_BOOL_MAX          = 32'h0000_0001;
   localparam logic [31:0] VAL_CODE_MAX          = 32'h0000_FFFF;

   // Momentary action length, in clock cycles
   localparam int unsigned PULSE_CYCLES          = 4;
   localparam logic [3:0]  PULSE_COUNT           = 4'(PULSE_CYCLES);

   typedef struct packed
   {
      logic        write;
      logic [9:0]  number;
      logic [31:0] value;
      logic        frame_ok;
   } param_req_t;

   typedef struct packed
   {
      logic        is_write;
      logic        ok;
      logic [7:0]  reply;
      logic [31:0] value;
      logic [7:0]  check;
   } param_rsp_t;

   typedef struct packed
   {
      logic       motor_energized;
      logic       start_present;
      logic       inch_mode;
      logic       remote_analog;
      logic [1:0] preset_inputs;
      logic [7:0] state_code;
      logic       running;
   } drive_status_t;

   typedef enum logic [1:0]
   {
      ST_INIT = 2'b00,
      ST_IDLE = 2'b01,
      ST_RESP = 2'b10
   } handler_state_t;

endpackage

// ===== rtl/drive_serial_parameter_handler.sv
// Parameter handler behind the drive's serial link: control, fault and readout parameters.
// Assumes framing, addressing and log-on are decoded upstream; one request per req_valid pulse.
`timescale 1ns/1ns
module drive_serial_parameter_handler
   import param_handler_pkg::*;
(
   input  wire logic          ref_clk_in,
   input  wire logic          rst_n_in,
   input  wire param_req_t    req_in,
   input  wire logic          req_valid_in,
   input  wire logic [7:0]    req_check_in,
   input  wire logic [7:0]    par_chars_xor_in,
   input  wire logic [7:0]    val_chars_xor_in,
   input  wire logic [31:0]   group_five_value_in,
   input  wire drive_status_t status_in,
   input  wire logic [15:0]   hw_fault_in,
   input  wire logic [15:0]   sw_fault_in,
   input  wire logic          reverse_terminal_in,
   input  wire logic          remote_terminal_in,
   input  wire logic          user_terminal_in,
   input  wire logic          start_done_in,
   input  wire logic          stop_done_in,
   input  wire logic          direction_done_in,
   input  wire logic          fault_clear_done_in,
   output param_rsp_t         rsp_out,
   output logic               rsp_valid_out,
   output logic [9:0]         group_five_number_out,
   output logic               start_terminal_out,
   output logic               run_permission_terminal_out,
   output logic               reverse_terminal_out,
   output logic               remote_terminal_out,
   output logic               user_terminal_out,
   output logic               fault_clear_terminal_out,
   output logic [15:0]        hw_fault_force_out,
   output logic [15:0]        sw_fault_force_out,
   output logic               display_readout_out
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   handler_state_t state_q;
   handler_state_t state_d;
   logic           start_pend_q;
   logic           stop_pend_q;
   logic           fwd_pend_q;
   logic           rev_pend_q;
   logic           clr_pend_q;
   logic           reverse_q;
   logic           remote_q;
   logic           user_q;
   logic [3:0]     start_cnt_q;
   logic [3:0]     stop_cnt_q;
   logic [3:0]     clr_cnt_q;
   logic [3:0]     hwf_cnt_q;
   logic [3:0]     swf_cnt_q;
   logic [15:0]    hwf_force_q;
   logic [15:0]    swf_force_q;
   param_rsp_t     rsp_q;
   logic           rsp_valid_q;

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   wire logic [9:0]  num      = req_in.number;
   wire logic [31:0] val      = req_in.value;
   wire logic        is_one   = (val == VAL_BOOL_MAX);
   wire logic        is_bool  = (val <= VAL_BOOL_MAX);
   wire logic        take     = req_valid_in && (state_q == ST_IDLE);
   wire logic        is_grp5  = (num >= PAR_GROUP_FIVE_FIRST) && (num <= PAR_GROUP_FIVE_LAST);
   wire logic        wr_ctrl  = (num == PAR_START_REQUEST) || (num == PAR_STOP_REQUEST) ||
                                (num == PAR_FORWARD_REQUEST) || (num == PAR_REVERSE_REQUEST) ||
                                (num == PAR_COMMAND_SOURCE) || (num == PAR_USER_INPUT) ||
                                (num == PAR_FAULT_CLEAR);
   wire logic        wr_force = (num == PAR_HW_FAULT_FORCE) || (num == PAR_SW_FAULT_FORCE);
   wire logic        hw_code_ok = ((val[15:0] & ~HWF_VALID_MASK) == 16'h0000) &&
                                  ((val[15:0] & (val[15:0] - 16'h0001)) == 16'h0000);
   wire logic        sw_code_ok = ((val[15:0] & ~SWF_VALID_MASK) == 16'h0000) &&
                                  ((val[15:0] & (val[15:0] - 16'h0001)) == 16'h0000);
   wire logic        range_ok = wr_ctrl ? is_bool :
                                (num == PAR_HW_FAULT_FORCE) ? (val <= VAL_CODE_MAX) && hw_code_ok :
                                (val <= VAL_CODE_MAX) && sw_code_ok;
   // Source and user emulation change terminal state, so they are locked while running
   wire logic        run_lock = status_in.running &&
                                ((num == PAR_COMMAND_SOURCE) || (num == PAR_USER_INPUT));
   wire logic        wr_ok    = req_in.frame_ok && (wr_ctrl || wr_force) && range_ok && !run_lock;
   wire logic        wr_go    = take && req_in.write && wr_ok;
   wire logic        wr_one   = wr_go && is_one;

   ////////////////////////////////////////////////////////////////////////////
   // Read mux
   logic [31:0] rd_val;
   logic        rd_ok;
   always_comb
   begin
      rd_ok = 1'b1;
      case (num)
         PAR_START_REQUEST    : rd_val = {31'h0, start_pend_q};
         PAR_STOP_REQUEST     : rd_val = {31'h0, stop_pend_q};
         PAR_FORWARD_REQUEST  : rd_val = {31'h0, fwd_pend_q};
         PAR_REVERSE_REQUEST  : rd_val = {31'h0, rev_pend_q};
         PAR_FAULT_CLEAR      : rd_val = {31'h0, clr_pend_q};
         PAR_HW_FAULT_PRESENT : rd_val = {16'h0, hw_fault_in | hwf_force_q};
         PAR_SW_FAULT_PRESENT : rd_val = {16'h0, sw_fault_in | swf_force_q};
         PAR_MOTOR_ENERGIZED  : rd_val = {31'h0, status_in.motor_energized};
         PAR_DRIVE_STATE      : rd_val = {24'h0, status_in.state_code};
         PAR_START_PRESENT    : rd_val = {31'h0, status_in.start_present};
         PAR_DIRECTION        : rd_val = {31'h0, reverse_q};
         PAR_INCH_MODE        : rd_val = {31'h0, status_in.inch_mode};
         PAR_ANALOG_SOURCE    : rd_val = {31'h0, status_in.remote_analog};
         PAR_PRESET_INDEX     : rd_val = {30'h0, status_in.preset_inputs} + 32'h0000_0001;
         default              :
         begin
            rd_val = group_five_value_in;
            rd_ok  = is_grp5;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Block check
   wire logic [7:0] chk_raw = par_chars_xor_in ^ val_chars_xor_in ^ CHR_ETX;
   wire logic [7:0] chk     = (chk_raw < CHR_CTRL_LIMIT) ? (chk_raw + CHR_CTRL_LIMIT) : chk_raw;

   ////////////////////////////////////////////////////////////////////////////
   // Response
   param_rsp_t rsp_d;
   always_comb
   begin
      rsp_d.is_write = req_in.write;
      rsp_d.ok       = req_in.write ? wr_ok : rd_ok;
      rsp_d.reply    = wr_ok ? CHR_ACK : CHR_NAK;
      rsp_d.value    = req_in.write ? 32'h0 : rd_val;
      rsp_d.check    = chk;
   end

   always_comb
   begin
      case (state_q)
         ST_INIT : state_d = ST_IDLE;
         ST_IDLE : state_d = req_valid_in ? ST_RESP : ST_IDLE;
         ST_RESP : state_d = ST_IDLE;
         default : state_d = ST_IDLE;
      endcase
   end

   wire logic w_start = wr_one && (num == PAR_START_REQUEST);
   wire logic w_stop  = wr_one && (num == PAR_STOP_REQUEST);
   wire logic w_fwd   = wr_one && (num == PAR_FORWARD_REQUEST);
   wire logic w_rev   = wr_one && (num == PAR_REVERSE_REQUEST);
   wire logic w_src   = wr_go && (num == PAR_COMMAND_SOURCE);
   wire logic w_user  = wr_go && (num == PAR_USER_INPUT);
   wire logic w_clr   = wr_one && (num == PAR_FAULT_CLEAR);
   wire logic w_hwf   = wr_go && (num == PAR_HW_FAULT_FORCE);
   wire logic w_swf   = wr_go && (num == PAR_SW_FAULT_FORCE);

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_q     <= ST_INIT;
         rsp_q       <= '0;
         rsp_valid_q <= 1'b0;
      end
      else
      begin
         state_q     <= state_d;
         rsp_valid_q <= take;
         if (take)
            rsp_q <= rsp_d;
      end
   end

   // Pending flags: a new write wins over a completion in the same cycle
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         start_pend_q <= 1'b0;
         stop_pend_q  <= 1'b0;
         fwd_pend_q   <= 1'b0;
         rev_pend_q   <= 1'b0;
         clr_pend_q   <= 1'b0;
      end
      else
      begin
         start_pend_q <= w_start | (start_pend_q & ~start_done_in);
         stop_pend_q  <= w_stop  | (stop_pend_q  & ~stop_done_in);
         fwd_pend_q   <= w_fwd   | (fwd_pend_q   & ~direction_done_in);
         rev_pend_q   <= w_rev   | (rev_pend_q   & ~direction_done_in);
         clr_pend_q   <= w_clr   | (clr_pend_q   & ~fault_clear_done_in);
      end
   end

   // Latched terminal emulation, loaded from terminal levels on the first clock after reset
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         reverse_q <= 1'b0;
         remote_q  <= 1'b0;
         user_q    <= 1'b0;
      end
      else if (state_q == ST_INIT)
      begin
         reverse_q <= reverse_terminal_in;
         remote_q  <= remote_terminal_in;
         user_q    <= user_terminal_in;
      end
      else
      begin
         if (w_fwd)
            reverse_q <= 1'b0;
         else if (w_rev)
            reverse_q <= 1'b1;
         if (w_src)
            remote_q <= val[0];
         if (w_user)
            user_q <= val[0];
      end
   end

   // Momentary pulse counters
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         start_cnt_q <= 4'h0;
         stop_cnt_q  <= 4'h0;
         clr_cnt_q   <= 4'h0;
         hwf_cnt_q   <= 4'h0;
         swf_cnt_q   <= 4'h0;
         hwf_force_q <= HWF_NONE;
         swf_force_q <= SWF_NONE;
      end
      else
      begin
         start_cnt_q <= w_start ? PULSE_COUNT : start_cnt_q - {3'h0, |start_cnt_q};
         stop_cnt_q  <= w_stop  ? PULSE_COUNT : stop_cnt_q  - {3'h0, |stop_cnt_q};
         clr_cnt_q   <= w_clr   ? PULSE_COUNT : clr_cnt_q   - {3'h0, |clr_cnt_q};
         hwf_cnt_q   <= w_hwf   ? PULSE_COUNT : hwf_cnt_q   - {3'h0, |hwf_cnt_q};
         swf_cnt_q   <= w_swf   ? PULSE_COUNT : swf_cnt_q   - {3'h0, |swf_cnt_q};
         if (w_hwf)
            hwf_force_q <= val[15:0];
         else if (hwf_cnt_q == 4'h1)
            hwf_force_q <= HWF_NONE;
         if (w_swf)
            swf_force_q <= val[15:0];
         else if (swf_cnt_q == 4'h1)
            swf_force_q <= SWF_NONE;
      end
   end

   // Output flops
   logic       start_t_q;
   logic       runperm_t_q;
   logic       clr_t_q;
   logic [9:0] grp_num_q;
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         start_t_q   <= 1'b0;
         runperm_t_q <= 1'b1;
         clr_t_q     <= 1'b0;
         grp_num_q   <= 10'h000;
      end
      else
      begin
         start_t_q   <= w_start | (|start_cnt_q & (start_cnt_q != 4'h1));
         runperm_t_q <= ~(w_stop | (|stop_cnt_q & (stop_cnt_q != 4'h1)));
         clr_t_q     <= w_clr | (|clr_cnt_q & (clr_cnt_q != 4'h1));
         grp_num_q   <= num;
      end
   end

   assign rsp_out                     = rsp_q;
   assign rsp_valid_out               = rsp_valid_q;
   assign group_five_number_out       = grp_num_q;
   assign start_terminal_out          = start_t_q;
   assign run_permission_terminal_out = runperm_t_q;
   assign reverse_terminal_out        = reverse_q;
   assign remote_terminal_out         = remote_q;
   assign user_terminal_out           = user_q;
   assign fault_clear_terminal_out    = clr_t_q;
   assign hw_fault_force_out          = hwf_force_q;
   assign sw_fault_force_out          = swf_force_q;
   assign display_readout_out         = 1'b0;

endmodule // drive_serial_parameter_handler

// ===== verification/drive_param_checker_assertions.sv
// Checker for the serial parameter handler: reply codes, momentary actions, fault codes.
// Assumes it is bound to the handler's top module and sees only its ports.
`timescale 1ns/1ns
module drive_param_checker
   import param_handler_pkg::*;
(
   input wire logic        ref_clk_in,
   input wire logic        rst_n_in,
   input wire param_rsp_t  rsp_out,
   input wire logic        rsp_valid_out,
   input wire logic        start_terminal_out,
   input wire logic        run_permission_terminal_out,
   input wire logic        reverse_terminal_out,
   input wire logic        remote_terminal_out,
   input wire logic        user_terminal_out,
   input wire logic        fault_clear_terminal_out,
   input wire logic [15:0] hw_fault_force_out,
   input wire logic [15:0] sw_fault_force_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////
   // Momentary action: four cycles active, then released
   sequence s_held(s);
      s [*4] ##1 !s;
   endsequence
   sequence s_write_reply(good);
      rsp_valid_out && rsp_out.is_write && (rsp_out.ok == good);
   endsequence
   AST_START_PULSE: assert property ($rose(start_terminal_out) |-> s_held(start_terminal_out))
      else $error("start pulse length wrong");
   AST_STOP_PULSE: assert property ($fell(run_permission_terminal_out) |-> s_held(!run_permission_terminal_out))
      else $error("stop pulse length wrong");
   AST_CLEAR_PULSE: assert property ($rose(fault_clear_terminal_out) |-> s_held(fault_clear_terminal_out))
      else $error("fault clear pulse length wrong");
   AST_HW_FORCE_PULSE: assert property ($rose(|hw_fault_force_out) |-> s_held(|hw_fault_force_out))
      else $error("forced hardware fault length wrong");
   AST_SW_FORCE_PULSE: assert property ($rose(|sw_fault_force_out) |-> s_held(|sw_fault_force_out))
      else $error("forced software fault length wrong");
   AST_HW_CODE: assert property (|hw_fault_force_out |-> $onehot(hw_fault_force_out & HWF_VALID_MASK))
      else $error("forced hardware code not defined");
   AST_SW_CODE: assert property (|sw_fault_force_out |-> $onehot(sw_fault_force_out & SWF_VALID_MASK))
      else $error("forced software code not defined");
   AST_NAK_KEEPS: assert property (s_write_reply(1'b0) |-> rsp_out.reply == CHR_NAK && $stable(reverse_terminal_out) && $stable(remote_terminal_out) && $stable(user_terminal_out))
      else $error("refused write changed state");
   AST_ACK: assert property (s_write_reply(1'b1) |-> rsp_out.reply == CHR_ACK ##1 !rsp_valid_out)
      else $error("accepted write reply wrong");
   AST_CHECK_CHAR: assert property (rsp_valid_out && !rsp_out.is_write && rsp_out.ok |-> rsp_out.check >= CHR_CTRL_LIMIT)
      else $error("read check char below limit");
endmodule // drive_param_checker

bind drive_serial_parameter_handler drive_param_checker u_drive_param_checker
(
   .ref_clk_in, .rst_n_in, .rsp_out, .rsp_valid_out, .start_terminal_out, .run_permission_terminal_out,
   .reverse_terminal_out, .remote_terminal_out, .user_terminal_out, .fault_clear_terminal_out,
   .hw_fault_force_out, .sw_fault_force_out
);

// ===== verification/host_link_model.sv
// Host side of the parameter link: one request at a time, reply collected.
// Assumes the bench calls xfer; requests change at the falling edge.
`timescale 1ns/1ns
module host_link_model
   import param_handler_pkg::*;
(
   input  wire logic       ref_clk_in,
   input  wire logic       rsp_valid_in,
   input  wire param_rsp_t rsp_in,
   output param_req_t      req_out,
   output logic            req_valid_out
);
   initial
   begin
      req_out = '0;
      req_valid_out = 1'b0;
   end
   // Frame check result comes with the request; reply stays unknown if none arrives
   task automatic xfer(input logic w, input logic [9:0] num, input logic [31:0] val, input logic fok,
                       output param_rsp_t r);
      r = 'x;
      @(negedge ref_clk_in);
      req_out = '{w, num, val, fok};
      req_valid_out = 1'b1;
      @(negedge ref_clk_in);
      req_valid_out = 1'b0;
      req_out = ~req_out;
      for (int n = 0; n < 4; n++)
      begin
         if (rsp_valid_in)
         begin
            r = rsp_in;
            break;
         end
         @(negedge ref_clk_in);
      end
   endtask
endmodule // host_link_model

// ===== verification/tb_top.sv
// Testbench for the serial parameter handler: writes, refusals, readbacks and readouts.
// Assumes the host model issues requests; other inputs change at the falling edge.
`timescale 1ns/1ns
module tb_top;
   import param_handler_pkg::*;
   logic          ref_clk_in = 1'b0, rst_n_in = 1'b0, req_valid_in, rsp_valid_out, display_readout_out;
   logic          reverse_terminal_in, remote_terminal_in, user_terminal_in, sel, ok;
   logic          start_terminal_out, run_permission_terminal_out, fault_clear_terminal_out;
   logic          reverse_terminal_out, remote_terminal_out, user_terminal_out;
   param_req_t    req_in;
   param_rsp_t    rsp_out, r;
   drive_status_t status_in = '0;
   logic [7:0]    req_check_in = 8'h00, par_chars_xor_in = 8'h00, val_chars_xor_in = 8'h00;
   logic [31:0]   group_five_value_in = 32'h0;
   logic [15:0]   hw_fault_in = 16'h0, sw_fault_in = 16'h0, hw_fault_force_out, sw_fault_force_out, code;
   logic [15:0]   rnd = 16'h33F9;
   logic [9:0]    group_five_number_out, num;
   logic [3:0]    done = 4'h0;
   logic [9:0]    mom_num [3] = '{PAR_START_REQUEST, PAR_STOP_REQUEST, PAR_FAULT_CLEAR};
   logic [2:0]    mom_exp [3] = '{3'b110, 3'b000, 3'b011};
   int            mom_done [3] = '{0, 1, 3};
   int            failures = 0, n_checks = 0, cycles = 0;
   always #25 ref_clk_in = ~ref_clk_in;
   drive_serial_parameter_handler u_drive_serial_parameter_handler
   (
      .ref_clk_in, .rst_n_in, .req_in, .req_valid_in, .req_check_in, .par_chars_xor_in, .val_chars_xor_in,
      .group_five_value_in, .status_in, .hw_fault_in, .sw_fault_in, .reverse_terminal_in, .remote_terminal_in,
      .user_terminal_in, .start_done_in(done[0]), .stop_done_in(done[1]), .direction_done_in(done[2]),
      .fault_clear_done_in(done[3]), .rsp_out, .rsp_valid_out, .group_five_number_out, .start_terminal_out,
      .run_permission_terminal_out, .reverse_terminal_out, .remote_terminal_out, .user_terminal_out,
      .fault_clear_terminal_out, .hw_fault_force_out, .sw_fault_force_out, .display_readout_out
   );
   host_link_model u_host_link_model
   (
      .ref_clk_in, .rsp_valid_in(rsp_valid_out), .rsp_in(rsp_out), .req_out(req_in), .req_valid_out(req_valid_in)
   );
   ////////////////////////////////////////////////////////////
   function automatic logic [15:0] next_rnd(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function automatic logic [7:0] bcc(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] x;
      x = a ^ b ^ 8'h03;
      return (x < 8'h20) ? x + 8'h20 : x;
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      if (failures == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [9:0] n, input logic [31:0] v, input logic fok, input logic [7:0] rep);
      u_host_link_model.xfer(1'b1, n, v, fok, r);
      check("write reply", 32'(r.reply), 32'(rep));
   endtask
   task automatic rd(input logic [9:0] n, input logic [31:0] exp);
      {par_chars_xor_in, val_chars_xor_in} = rnd;
      rnd = next_rnd(rnd);
      u_host_link_model.xfer(1'b0, n, 32'h0, 1'b1, r);
      check("read value", r.value, exp);
      check("read check", 32'(r.check), 32'(bcc(par_chars_xor_in, val_chars_xor_in)));
   endtask
   task automatic pulse_done(input int i);
      done[i] = 1'b1;
      @(negedge ref_clk_in);
      done[i] = 1'b0;
   endtask
   always @(posedge ref_clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////
   initial
   begin
      {user_terminal_in, remote_terminal_in, reverse_terminal_in} = rnd[2:0];
      repeat (3) @(negedge ref_clk_in);
      rst_n_in = 1'b1;
      repeat (2) @(negedge ref_clk_in);
      check("start levels", 32'({reverse_terminal_out, remote_terminal_out, user_terminal_out}), 32'(3'b100));
      {user_terminal_in, remote_terminal_in, reverse_terminal_in} = 3'b111;
      wr(PAR_START_REQUEST, 32'h2, 1'b1, CHR_NAK);
      wr(10'h38A, 32'h1, 1'b1, CHR_NAK);
      for (int i = 0; i < 3; i++)
      begin
         wr(mom_num[i], 32'h1, 1'b1, CHR_ACK);
         check("momentary", 32'({start_terminal_out, run_permission_terminal_out, fault_clear_terminal_out}), 32'(mom_exp[i]));
         rd(mom_num[i], 32'h1);
         pulse_done(mom_done[i]);
         rd(mom_num[i], 32'h0);
      end
      for (int v = 0; v < 2; v++)
      begin
         wr(v ? PAR_REVERSE_REQUEST : PAR_FORWARD_REQUEST, 32'h1, 1'b1, CHR_ACK);
         check("reverse level", 32'(reverse_terminal_out), 32'(v));
         rd(PAR_DIRECTION, 32'(v));
         pulse_done(2);
         rd(v ? PAR_REVERSE_REQUEST : PAR_FORWARD_REQUEST, 32'h0);
      end
      status_in.running = 1'b1;
      wr(PAR_COMMAND_SOURCE, 32'h1, 1'b1, CHR_NAK);
      status_in.running = 1'b0;
      wr(PAR_USER_INPUT, 32'h1, 1'b0, CHR_NAK);
      check("refused keeps", 32'({remote_terminal_out, user_terminal_out}), 32'h0);
      for (int v = 0; v < 4; v++)
      begin
         wr(v[0] ? PAR_USER_INPUT : PAR_COMMAND_SOURCE, 32'(!v[1]), 1'b1, CHR_ACK);
         check("selected input", 32'(v[0] ? user_terminal_out : remote_terminal_out), 32'(!v[1]));
      end
      wr(PAR_HW_FAULT_FORCE, 32'h3, 1'b1, CHR_NAK);
      for (int b = 0; b < 32; b++)
      begin
         code = 16'h1 << b[3:0];
         sel = b[4];
         ok = ((sel ? SWF_VALID_MASK : HWF_VALID_MASK) & code) != 16'h0;
         wr(sel ? PAR_SW_FAULT_FORCE : PAR_HW_FAULT_FORCE, 32'(code), 1'b1, ok ? CHR_ACK : CHR_NAK);
         check("forced fault", 32'(sel ? sw_fault_force_out : hw_fault_force_out), 32'(ok ? code : 16'h0));
         repeat (5) @(negedge ref_clk_in);
      end
      repeat (12)
      begin
         status_in = drive_status_t'(rnd[14:0]);
         {hw_fault_in, sw_fault_in, group_five_value_in} = {rnd, ~rnd, next_rnd(rnd), rnd};
         req_check_in = rnd[7:0];
         num = PAR_GROUP_FIVE_FIRST + 10'(rnd % 16'd100);
         rd(PAR_HW_FAULT_PRESENT, 32'(hw_fault_in));
         rd(PAR_SW_FAULT_PRESENT, 32'(sw_fault_in));
         rd(PAR_MOTOR_ENERGIZED, 32'(status_in.motor_energized));
         rd(PAR_DRIVE_STATE, 32'(status_in.state_code));
         rd(PAR_START_PRESENT, 32'(status_in.start_present));
         rd(PAR_INCH_MODE, 32'(status_in.inch_mode));
         rd(PAR_ANALOG_SOURCE, 32'(status_in.remote_analog));
         rd(PAR_PRESET_INDEX, 32'(status_in.preset_inputs) + 32'h1);
         rd(num, group_five_value_in);
         check("group five number", 32'(group_five_number_out), 32'(num));
      end
      check("display", 32'(display_readout_out), 32'h0);
      // Mid-run reset: latched terminals cleared and run permission set, then recaptured from the new levels
      rst_n_in = 1'b0;
      @(negedge ref_clk_in);
      check("reset levels", 32'({run_permission_terminal_out, reverse_terminal_out, remote_terminal_out, user_terminal_out}), 32'h8);
      repeat (2) @(negedge ref_clk_in);
      rst_n_in = 1'b1;
      wr(PAR_START_REQUEST, 32'h0, 1'b1, CHR_ACK);
      check("start idle", 32'(start_terminal_out), 32'h0);
      check("restart levels", 32'({reverse_terminal_out, remote_terminal_out, user_terminal_out}), 32'h7);
      rd(PAR_START_REQUEST, 32'h0);
      conclude();
   end
endmodule // tb_top
